/* wave_play.sv */
// Added by the designer: the address map and register access over AXI4-Lite.
module wave_play #(
  parameter int ADDR_W = 12,
  parameter int SAMPLE_W = 16,
  parameter bit EXT_MEM = 1'b0
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // link
  input wire logic trig_i,
  input wire logic ext_ref_i,
  output logic [SAMPLE_W-1:0] dac_data_o,
  output logic dac_valid_o,
  output logic playing_o
);

  typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [3:0] scale;
    logic [ADDR_W-1:0] pat_len;
    logic [ADDR_W-1:0] burst_len;
    logic [ADDR_W-1:0] waddr;
    wave_play_pkg::load_t ld;
    wave_play_pkg::play_state_t st;
    logic trig_d;
    logic ref_d;
    logic [4:0] cnt;
    logic [ADDR_W-1:0] rd_ptr;
    logic [ADDR_W-1:0] burst_cnt;
    logic [SAMPLE_W-1:0] dac;
    logic dac_v;
    logic rd_pend;
  } state_t;

  state_t st_reg, st_next;
  logic [SAMPLE_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic mem_we;
  logic [SAMPLE_W-1:0] mem_q;
  logic trig_edge, ref_edge, tick;

  function automatic logic [4:0] period_of(input logic [3:0] code);
    // int-ref and x1/x2.. collapse to one tick per period of the reference
    if (code > 4'h4) begin
      period_of = 5'(1 << (code - 4'h4));
    end else begin
      period_of = 5'h01;
    end
  endfunction

  always_ff @(posedge core_clk_i) begin
    if (mem_we) begin
      mem[st_reg.waddr] <= st_reg.wdata[SAMPLE_W-1:0];
    end
    // fetch at the pointer's next value so the word is ready on the very first tick
    mem_q <= mem[st_next.rd_ptr];
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic wr_fire;
    logic [7:0] ra;
    logic go;
    logic [ADDR_W:0] n_len;
    wr_fire = 1'b0;
    ra = 8'h00;
    go = 1'b0;
    n_len = '0;
    st_next = st_reg;
    mem_we = 1'b0;
    trig_edge = 1'b0;
    ref_edge = 1'b0;
    tick = 1'b0;
    st_next.trig_d = trig_i;
    st_next.ref_d = ext_ref_i;
    st_next.ctrl[wave_play_pkg::CTRL_RESTART_BIT] = 1'b0;
    st_next.ctrl[wave_play_pkg::CTRL_CLRLOAD_BIT] = 1'b0;
    // bus write side: address and data taken in either order
    if (s_axi_awvalid && !st_reg.aw_got) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_got) begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata;
    end
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      wr_fire = 1'b1;
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = wave_play_pkg::RESP_OKAY;
      unique case (st_reg.awaddr)
        wave_play_pkg::CTRL_OFF: st_next.ctrl = st_reg.wdata;
        wave_play_pkg::DIV_OFF: begin
          if (st_reg.wdata[3:0] <= wave_play_pkg::SCALE_MAX) begin
            st_next.scale = st_reg.wdata[3:0];
          end else begin
            st_next.ld.reject = 1'b1;
            st_next.bresp = wave_play_pkg::RESP_SLVERR;
          end
        end
        wave_play_pkg::PAT_OFF: begin
          // a new pattern counts against every limit; refuse rather than truncate
          n_len = {1'b0, st_reg.wdata[ADDR_W-1:0]};
          if (n_len < (ADDR_W+1)'(wave_play_pkg::MIN_PAT_LEN)
              || st_reg.ld.count >= 13'(wave_play_pkg::MAX_PATTERNS)
              || st_reg.ld.in_pkg >= 10'(wave_play_pkg::MAX_PER_PKG)) begin
            st_next.ld.reject = 1'b1;
            st_next.bresp = wave_play_pkg::RESP_SLVERR;
          end else begin
            st_next.pat_len = st_reg.wdata[ADDR_W-1:0];
            st_next.ld.count = st_reg.ld.count + 13'h0001;
            st_next.ld.in_pkg = st_reg.ld.in_pkg + 10'h001;
            st_next.waddr = '0;
          end
        end
        wave_play_pkg::BURST_OFF: st_next.burst_len = st_reg.wdata[ADDR_W-1:0];
        wave_play_pkg::LOAD_OFF: begin
          if (st_reg.ld.pkgs >= 7'(wave_play_pkg::MAX_PKGS)) begin
            st_next.ld.reject = 1'b1;
            st_next.bresp = wave_play_pkg::RESP_SLVERR;
          end else begin
            st_next.ld.pkgs = st_reg.ld.pkgs + 7'h01;
            st_next.ld.in_pkg = '0;
          end
        end
        wave_play_pkg::WDATA_OFF: begin
          mem_we = 1'b1;
          st_next.waddr = st_reg.waddr + 1'b1;
        end
        default: st_next.bresp = wave_play_pkg::RESP_SLVERR;
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_next.ctrl[wave_play_pkg::CTRL_CLRLOAD_BIT]) begin
      st_next.ld = '0;
    end
    // bus read side
    if (s_axi_arvalid && !st_reg.rvalid) begin
      ra = s_axi_araddr;
      st_next.rvalid = 1'b1;
      st_next.rdata = 32'h0000_0000;
      unique case (ra)
        wave_play_pkg::CTRL_OFF: st_next.rdata = st_reg.ctrl;
        wave_play_pkg::DIV_OFF: st_next.rdata = 32'(st_reg.scale);
        wave_play_pkg::PAT_OFF: st_next.rdata = 32'(st_reg.pat_len);
        wave_play_pkg::BURST_OFF: st_next.rdata = 32'(st_reg.burst_len);
        wave_play_pkg::LOAD_OFF: st_next.rdata = {st_reg.ld.in_pkg, st_reg.ld.pkgs, 2'h0, st_reg.ld.count};
        wave_play_pkg::STAT_OFF: st_next.rdata = {28'h0, st_reg.ld.reject, st_reg.st, st_reg.dac_v};
        wave_play_pkg::CAP_OFF:
          st_next.rdata = EXT_MEM ? wave_play_pkg::MEM_EXT_SAMPLES : wave_play_pkg::MEM_BASE_SAMPLES;
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    // sampling tick: internal reference = core clock, else divided external edges
    ref_edge = ext_ref_i && !st_reg.ref_d;
    if (!st_reg.ctrl[wave_play_pkg::CTRL_EXTREF_BIT]) begin
      tick = 1'b1;
    end else if (ref_edge) begin
      // multiply codes cannot exceed the core rate here; they run at one per edge
      if (st_reg.cnt + 5'h01 >= period_of(st_reg.scale)) begin
        tick = 1'b1;
        st_next.cnt = '0;
      end else begin
        st_next.cnt = st_reg.cnt + 5'h01;
      end
    end
    trig_edge = st_reg.ctrl[wave_play_pkg::CTRL_FALL_BIT] ? (st_reg.trig_d && !trig_i)
                                                          : (!st_reg.trig_d && trig_i);
    st_next.dac_v = 1'b0;
    unique case (st_reg.st)
      wave_play_pkg::ST_IDLE: begin
        if (st_reg.ctrl[wave_play_pkg::CTRL_RUN_BIT]) begin
          st_next.st = wave_play_pkg::ST_ARMED;
        end
      end
      wave_play_pkg::ST_ARMED: begin
        go = trig_edge;
        if (go) begin
          st_next.st = wave_play_pkg::ST_PLAY;
          st_next.rd_ptr = '0;
          st_next.burst_cnt = '0;
        end
      end
      wave_play_pkg::ST_PLAY: begin
        if (tick) begin
          st_next.dac = mem_q;
          st_next.dac_v = 1'b1;
          st_next.rd_ptr = (st_reg.rd_ptr + 1'b1 >= st_reg.pat_len) ? '0 : st_reg.rd_ptr + 1'b1;
          st_next.burst_cnt = st_reg.burst_cnt + 1'b1;
          if (st_reg.ctrl[wave_play_pkg::CTRL_FRAME_BIT]
              && st_reg.burst_cnt + 1'b1 >= st_reg.burst_len) begin
            st_next.st = wave_play_pkg::ST_ARMED;
          end
        end
      end
      default: st_next.st = wave_play_pkg::ST_IDLE;
    endcase
    if (st_reg.ctrl[wave_play_pkg::CTRL_RESTART_BIT]) begin
      st_next.rd_ptr = '0;
    end
    if (!st_reg.ctrl[wave_play_pkg::CTRL_RUN_BIT]) begin
      st_next.st = wave_play_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = !st_reg.aw_got;
  assign s_axi_wready = !st_reg.w_got;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = wave_play_pkg::RESP_OKAY;
  assign dac_data_o = st_reg.dac;
  assign dac_valid_o = st_reg.dac_v;
  assign playing_o = (st_reg.st == wave_play_pkg::ST_PLAY);

  a_start_on_edge: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (st_reg.st == wave_play_pkg::ST_ARMED && trig_edge && st_reg.ctrl[0]) |=> playing_o)
    else $error("trigger edge did not start playback");
  a_frame_halts: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (playing_o && tick && st_reg.ctrl[1] && st_reg.ctrl[0] && st_reg.burst_cnt + 1'b1 >= st_reg.burst_len)
    |=> !playing_o) else $error("frame burst did not halt");
  a_short_reject: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid && st_reg.awaddr == wave_play_pkg::PAT_OFF
     && st_reg.wdata[ADDR_W-1:0] < ADDR_W'(wave_play_pkg::MIN_PAT_LEN)) |=> s_axi_bresp == wave_play_pkg::RESP_SLVERR)
    else $error("short pattern accepted");
  a_count_limit: assert property (@(posedge core_clk_i) disable iff (rst_i)
    st_reg.ld.count <= 13'(wave_play_pkg::MAX_PATTERNS)) else $error("pattern count over limit");
  a_pkg_limit: assert property (@(posedge core_clk_i) disable iff (rst_i)
    st_reg.ld.pkgs <= 7'(wave_play_pkg::MAX_PKGS) && st_reg.ld.in_pkg <= 10'(wave_play_pkg::MAX_PER_PKG))
    else $error("package limit exceeded");
  a_sample_per_tick: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (playing_o && tick) |=> dac_valid_o) else $error("no sample on tick");
  a_idle_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !playing_o |=> !dac_valid_o) else $error("sample while stopped");
  a_scale_legal: assert property (@(posedge core_clk_i) disable iff (rst_i)
    st_reg.scale <= wave_play_pkg::SCALE_MAX) else $error("illegal scale code");
  c_start_play: cover property (@(posedge core_clk_i) disable iff (rst_i) $rose(playing_o));
  c_frame_end: cover property (@(posedge core_clk_i) disable iff (rst_i) $fell(playing_o) && st_reg.ctrl[0]);
  c_reject: cover property (@(posedge core_clk_i) disable iff (rst_i) $rose(st_reg.ld.reject));
endmodule

/* wave_play_pkg.sv */
// Functional notes
// - external reference scaled by one power-of-two factor; the code only divides (codes 5..8), codes 0..4 give one tick per edge
// - start trigger begins continuous pattern output
// - frame trigger emits one burst, then waits
// - setting selects start or frame trigger
// - trigger edge polarity is selectable
// - at most 4096 patterns, minimum 128 samples
// - 1000 patterns per package, 100 packages
// - memory 64M samples, 256M with extension; the code holds 2^ADDR_W samples and only reports these sizes at CAP_OFF
package wave_play_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] DIV_OFF = 8'h04;
  localparam logic [7:0] PAT_OFF = 8'h08;
  localparam logic [7:0] BURST_OFF = 8'h0c;
  localparam logic [7:0] LOAD_OFF = 8'h10;
  localparam logic [7:0] STAT_OFF = 8'h14;
  localparam logic [7:0] WDATA_OFF = 8'h18;
  localparam logic [7:0] CAP_OFF = 8'h1c;
  // ctrl field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_FRAME_BIT = 1;
  localparam int CTRL_FALL_BIT = 2;
  localparam int CTRL_EXTREF_BIT = 3;
  localparam int CTRL_RESTART_BIT = 4;
  localparam int CTRL_CLRLOAD_BIT = 5;
  // limits
  localparam int MAX_PATTERNS = 4096;
  localparam int MIN_PAT_LEN = 128;
  localparam int MAX_PER_PKG = 1000;
  localparam int MAX_PKGS = 100;
  localparam logic [31:0] MEM_BASE_SAMPLES = 32'h0400_0000;
  localparam logic [31:0] MEM_EXT_SAMPLES = 32'h1000_0000;
  // scale codes: 0..4 multiply by 2^n, 5..8 divide by 2^(n-4); the code runs codes 0..4 at one tick per edge
  localparam logic [3:0] SCALE_MAX = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_PLAY} play_state_t;

  typedef struct packed {
    logic [3:0] scale;
    logic [3:0] phase;
    logic [3:0] sub;
  } clk_gen_t;

  typedef struct packed {
    logic [12:0] count;
    logic [6:0] pkgs;
    logic [9:0] in_pkg;
    logic reject;
  } load_t;
endpackage

/* wave_play_src.sv */
module wave_play_src (
  // clock
  input wire logic core_clk_i,
  // far-side lines
  output logic trig_o,
  output logic ext_ref_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] half_cnt = 2'h0;
  initial begin
    trig_o = 1'b0;
    ext_ref_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  // reference runs free, one rising edge every 6 core cycles
  always @(posedge core_clk_i) begin
    half_cnt <= (half_cnt == 2'h2) ? 2'h0 : half_cnt + 2'h1;
    if (half_cnt == 2'h2) begin
      ext_ref_o <= ~ext_ref_o;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // level is held a few cycles so a synchroniser cannot miss it
  task automatic drive_trig(input logic lvl);
    @(posedge core_clk_i);
    trig_o <= lvl;
    repeat (4) @(posedge core_clk_i);
  endtask
endmodule

/* wave_play_tb.sv */
module wave_play_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 1'b0, rst_i = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_val;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, seq_on = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic trig, ext_ref, dac_valid_o, playing_o;
  logic [15:0] dac_data_o;
  int errors = 0, n_compared = 0, nsamp = 0, cyc = 0, last_cyc = 0, gap = 0, seq_cnt = 0, bad;
  always #25 core_clk_i = ~core_clk_i;
  wave_play #(.ADDR_W(12), .SAMPLE_W(16), .EXT_MEM(1'b0)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .trig_i(trig), .ext_ref_i(ext_ref),
    .dac_data_o(dac_data_o), .dac_valid_o(dac_valid_o), .playing_o(playing_o));
  wave_play_src src (.core_clk_i(core_clk_i), .trig_o(trig), .ext_ref_o(ext_ref));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd_val = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  // a quiet tail after the last sample shows that nothing more follows
  task automatic trig_go(input logic lvl, input int n);
    @(negedge core_clk_i);
    nsamp = 0;
    src.drive_trig(lvl);
    while (nsamp < n) @(negedge core_clk_i);
    repeat (20) @(negedge core_clk_i);
  endtask
  task automatic clear_load();
    wr(wave_play_pkg::CTRL_OFF, 32'h20);
    wr(wave_play_pkg::CTRL_OFF, 32'h0);
    bad = 0;
  endtask
  task test_done();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_i) begin
    cyc++;
    if (dac_valid_o === 1'b1) begin
      nsamp++;
      gap = cyc - last_cyc;
      last_cyc = cyc;
      // pattern word i holds i, so the k-th sample of a run must read k
      if (seq_on) begin
        chk(dac_data_o, 32'(seq_cnt));
        seq_cnt++;
      end
    end
  end
  initial begin
    repeat (80000) @(posedge core_clk_i);
    errors++;
    test_done();
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(wave_play_pkg::CTRL_OFF);
    chk(rd_val, wave_play_pkg::CTRL_RST);
    chk(resp, wave_play_pkg::RESP_OKAY);
    rd(wave_play_pkg::CAP_OFF);
    chk(rd_val, wave_play_pkg::MEM_BASE_SAMPLES);
    wr(8'h20, 32'h1);
    chk(resp, wave_play_pkg::RESP_SLVERR);
    wr(wave_play_pkg::DIV_OFF, 32'h9);
    chk(resp, wave_play_pkg::RESP_SLVERR);
    rd(wave_play_pkg::STAT_OFF);
    chk(rd_val[3], 1'b1);
    wr(wave_play_pkg::PAT_OFF, 32'h7f);
    chk(resp, wave_play_pkg::RESP_SLVERR);
    $display("test registers done");
    clear_load();
    for (int g = 0; g < 5; g++) begin
      if (g > 0) wr(wave_play_pkg::LOAD_OFF, 32'h0);
      bad += int'(resp !== wave_play_pkg::RESP_OKAY);
      for (int i = 0; i < ((g < 4) ? 1000 : 96); i++) begin
        wr(wave_play_pkg::PAT_OFF, 32'h80);
        bad += int'(resp !== wave_play_pkg::RESP_OKAY);
      end
      if (g == 0) wr(wave_play_pkg::PAT_OFF, 32'h80);
      if (g == 0) chk(resp, wave_play_pkg::RESP_SLVERR);
    end
    chk(bad, 0);
    wr(wave_play_pkg::PAT_OFF, 32'h80);
    chk(resp, wave_play_pkg::RESP_SLVERR);
    rd(wave_play_pkg::LOAD_OFF);
    chk(rd_val[12:0], 13'h1000);
    // whether the opening package counts is left open, so only 99 and 101 are judged
    clear_load();
    for (int i = 0; i < 99; i++) begin
      wr(wave_play_pkg::LOAD_OFF, 32'h0);
      bad += int'(resp !== wave_play_pkg::RESP_OKAY);
    end
    chk(bad, 0);
    wr(wave_play_pkg::LOAD_OFF, 32'h0);
    wr(wave_play_pkg::LOAD_OFF, 32'h0);
    chk(resp, wave_play_pkg::RESP_SLVERR);
    $display("test load limits done");
    clear_load();
    wr(wave_play_pkg::PAT_OFF, 32'h80);
    for (int i = 0; i < 128; i++) wr(wave_play_pkg::WDATA_OFF, i);
    wr(wave_play_pkg::BURST_OFF, 32'h4);
    wr(wave_play_pkg::CTRL_OFF, 32'h3);
    trig_go(1'b1, 4);
    chk(nsamp, 4);
    chk(playing_o, 1'b0);
    trig_go(1'b0, 0);
    chk(nsamp, 0);
    trig_go(1'b1, 4);
    chk(nsamp, 4);
    wr(wave_play_pkg::CTRL_OFF, 32'h7);
    trig_go(1'b0, 4);
    chk(nsamp, 4);
    trig_go(1'b1, 0);
    chk(nsamp, 0);
    $display("test frame trigger done");
    wr(wave_play_pkg::CTRL_OFF, 32'h5);
    seq_on = 1'b1;
    src.drive_trig(1'b0);
    while (playing_o !== 1'b1) @(negedge core_clk_i);
    nsamp = 0;
    repeat (40) @(negedge core_clk_i);
    chk(nsamp, 40);
    chk(playing_o, 1'b1);
    seq_on = 1'b0;
    wr(wave_play_pkg::CTRL_OFF, 32'h0);
    repeat (5) @(negedge core_clk_i);
    chk(playing_o, 1'b0);
    $display("test start trigger done");
    wr(wave_play_pkg::BURST_OFF, 32'h2);
    for (int c = 0; c <= 8; c++) begin
      wr(wave_play_pkg::DIV_OFF, c);
      chk(resp, wave_play_pkg::RESP_OKAY);
      wr(wave_play_pkg::CTRL_OFF, 32'hb);
      trig_go(1'b1, 2);
      chk(gap, 6 << ((c > 4) ? c - 4 : 0));
      wr(wave_play_pkg::CTRL_OFF, 32'h0);
      src.drive_trig(1'b0);
    end
    $display("test reference scaling done");
    test_done();
  end
endmodule
